/* pomx_pkg.sv */
// Package for the port 0 output pin multiplexer: strap codes, roles, carriers
package pomx_pkg;

   // Width of the output data bus
   localparam int DATA_W = 4;
   // Width of the role strap
   localparam int STRAP_W = 3;

   // Strap code values
   localparam logic [2:0] CODE_MAC       = 3'h0;
   localparam logic [2:0] CODE_PHY       = 3'h1;
   localparam logic [2:0] CODE_FAST_LO   = 3'h2;
   localparam logic [2:0] CODE_FAST_HI   = 3'h3;
   localparam logic [2:0] CODE_RED_LO    = 3'h4;
   localparam logic [2:0] CODE_RED_HI    = 3'h5;
   localparam logic [2:0] CODE_RED_CKIN  = 3'h6;
   localparam logic [2:0] CODE_RESERVED  = 3'h7;

   // Reset values of the captured strap and outputs
   localparam logic [2:0] STRAP_RST      = 3'h7;
   localparam logic [3:0] DATA_RST       = 4'h0;
   localparam logic       VALID_RST      = 1'b0;

   // Cycles after reset release before the strap is caught
   localparam logic [1:0] STRAP_SETTLE   = 2'h3;

   // Decoded port role
   typedef enum logic [2:0] {
      POMX_ROLE_MAC,
      POMX_ROLE_PHY,
      POMX_ROLE_FAST,
      POMX_ROLE_RED,
      POMX_ROLE_NONE
   } pomx_role_t;

   // One stream beat toward the link
   typedef struct packed {
      logic [3:0] data;
      logic       valid;
   } pomx_beat_t;

   // Pin drive bundle: level and enable per pin
   typedef struct packed {
      logic [3:0] data_o;
      logic [3:0] data_oe;
      logic       valid_o;
      logic       valid_oe;
   } pomx_pins_t;

endpackage

/* pomx_port0_out_mux.sv */
// Port 0 output-side pin multiplexer with strap decode and link-clock timing
`timescale 1ns/10ps

// Summary of operation
// - Decode strap: 000 MAC, 001 PHY, 111 reserved
// - Codes 010/011: double-rate PHY, clock strength low/high
// - Codes 100/101 reduced PHY, clock out; 110 in
// - MAC role: data bit n is transmit bit n
// - PHY roles: data bits carry receive data
// - Reduced PHY: only bits 1:0 carry data
// - PHY role plus isolate: data, valid drivers off
// - MAC role: valid pin is transmit enable
// - PHY roles: valid pin is receive data valid
// - Reduced PHY: valid pin is carrier-and-valid
// - Strap bit n shares output data pin n
// - Reduced PHY: 50 MHz clock, direction per strap
module pomx_port0_out_mux
   import pomx_pkg::*;
(
   input  wire logic                  CORE_CLK,          // Core clock, 25 MHz
   input  wire logic                  RST_B,             // Async reset, active low
   input  wire logic                  LINK_CLK,          // Port 0 output reference clock
   input  wire logic                  LINK_RST_B,        // Link-domain async reset, active low
   input  wire logic [2:0]            STRAP_PIN_I,       // Strap levels on data pins 2:0
   input  wire logic                  ISOLATE,           // Virtual PHY isolate control
   input  wire pomx_pkg::pomx_beat_t  TX_BEAT,           // Core beat, link-clock domain
   output logic      [3:0]            DATA_O,            // Output data pin levels
   output logic      [3:0]            DATA_OE,           // Output data pin enables
   output logic                       VALID_O,           // Data-valid pin level
   output logic                       VALID_OE,          // Data-valid pin enable
   output logic      [2:0]            ROLE_CODE,         // Captured strap code
   output logic                       STRAP_DONE,        // Strap has been caught
   output logic                       CLK_IS_OUTPUT,     // Device drives the ref clock
   output logic                       CLK_STRONG,        // High clock drive strength
   output logic                       CLK_OE,            // Ref clock driver enable
   output logic                       DOUBLE_RATE,       // 200 Mbps PHY role
   output logic                       MODE_RESERVED      // Unsupported strap code seen
);
   import pomx_pkg::*;

   // Strap synchroniser and capture (core domain)
   logic [2:0]  strap_s1_q;      // First stage, read only by second stage
   logic [2:0]  strap_s2_q;      // Second stage
   logic [2:0]  strap_q;         // Captured strap code
   logic        strap_done_q;    // Capture complete
   logic [1:0]  settle_q;        // Settle counter after reset release
   logic        iso_s1_q;        // Isolate sync first stage
   logic        iso_s2_q;        // Isolate sync second stage

   // Link domain copies of configuration
   logic [2:0]  lk_code_s1_q;    // Code copy, loaded once done has crossed
   logic [2:0]  lk_code_s2_q;    // Code copy, second stage
   logic        lk_done_s1_q;    // Done sync first stage
   logic        lk_done_s2_q;    // Done sync second stage
   logic        lk_iso_s1_q;     // Isolate sync first stage, link side
   logic        lk_iso_s2_q;     // Isolate sync second stage, link side
   pomx_role_t  lk_role;         // Decoded role, link domain
   pomx_pins_t  pins_d;          // Next pin drive
   pomx_pins_t  pins_q;          // Registered pin drive
   pomx_role_t  role;            // Decoded role, core domain

   // Strap pins come from outside, so two flops before anything looks at them
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_s1_q <= STRAP_RST;
         strap_s2_q <= STRAP_RST;
      end else begin
         strap_s1_q <= STRAP_PIN_I;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Isolate may come from another block; synchronise it anyway
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         iso_s1_q <= 1'b0;
         iso_s2_q <= 1'b0;
      end else begin
         iso_s1_q <= ISOLATE;
         iso_s2_q <= iso_s1_q;
      end
   end

   // Catch the strap a few cycles after release, while pins are still inputs
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         settle_q     <= 2'h0;
         strap_q      <= STRAP_RST;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         if (settle_q == STRAP_SETTLE) begin
            strap_q      <= strap_s2_q;
            strap_done_q <= 1'b1;
         end else begin
            settle_q <= settle_q + 2'h1;
         end
      end
   end

   // Map a strap code to a role; shared by both domains
   function automatic pomx_role_t decode_role(input logic [2:0] code);
      pomx_role_t r;
      r = POMX_ROLE_NONE;
      case (code)
         CODE_MAC:                         r = POMX_ROLE_MAC;
         CODE_PHY:                         r = POMX_ROLE_PHY;
         CODE_FAST_LO, CODE_FAST_HI:       r = POMX_ROLE_FAST;
         CODE_RED_LO, CODE_RED_HI,
         CODE_RED_CKIN:                    r = POMX_ROLE_RED;
         default:                          r = POMX_ROLE_NONE;
      endcase
      return r;
   endfunction

   assign role = decode_role(strap_q);

   // Clock pin configuration, core domain; stays off until strap is caught
   always_comb begin
      CLK_IS_OUTPUT = 1'b0;
      CLK_STRONG    = 1'b0;
      DOUBLE_RATE   = 1'b0;
      case (strap_q)
         CODE_PHY: begin
            CLK_IS_OUTPUT = 1'b1;
         end
         CODE_FAST_LO: begin
            CLK_IS_OUTPUT = 1'b1;
            DOUBLE_RATE   = 1'b1;
         end
         CODE_FAST_HI: begin
            CLK_IS_OUTPUT = 1'b1;
            CLK_STRONG    = 1'b1;
            DOUBLE_RATE   = 1'b1;
         end
         CODE_RED_LO: begin
            CLK_IS_OUTPUT = 1'b1;
         end
         CODE_RED_HI: begin
            CLK_IS_OUTPUT = 1'b1;
            CLK_STRONG    = 1'b1;
         end
         default: begin
            // MAC role and code 110 take the clock in
            CLK_IS_OUTPUT = 1'b0;
         end
      endcase
   end

   // Clock driver follows direction and isolate
   assign CLK_OE        = strap_done_q && CLK_IS_OUTPUT && !iso_s2_q;
   assign ROLE_CODE     = strap_q;
   assign STRAP_DONE    = strap_done_q;
   assign MODE_RESERVED = strap_done_q && (role == POMX_ROLE_NONE);

   // Only done crosses through the synchroniser; sampling the code word beside it
   // could catch a mix of old and new bits and steer the pins to a wrong role.
   // Once done has passed two link flops the code has long been still, so it is copied
   always_ff @(posedge LINK_CLK or negedge LINK_RST_B) begin
      if (!LINK_RST_B) begin
         lk_code_s1_q <= STRAP_RST;
         lk_code_s2_q <= STRAP_RST;
         lk_done_s1_q <= 1'b0;
         lk_done_s2_q <= 1'b0;
      end else begin
         if (lk_done_s2_q) begin
            lk_code_s1_q <= strap_q;
         end else begin
            lk_code_s1_q <= STRAP_RST;
         end
         lk_code_s2_q <= lk_code_s1_q;
         lk_done_s1_q <= strap_done_q;
         lk_done_s2_q <= lk_done_s1_q;
      end
   end

   // Isolate level brought into the link domain
   always_ff @(posedge LINK_CLK or negedge LINK_RST_B) begin
      if (!LINK_RST_B) begin
         lk_iso_s1_q <= 1'b0;
         lk_iso_s2_q <= 1'b0;
      end else begin
         lk_iso_s1_q <= iso_s2_q;
         lk_iso_s2_q <= lk_iso_s1_q;
      end
   end

   assign lk_role = lk_done_s2_q ? decode_role(lk_code_s2_q) : POMX_ROLE_NONE;

   // Pin steering per role; pins float until the strap is known
   always_comb begin
      pins_d = '0;
      case (lk_role)
         POMX_ROLE_MAC: begin
            pins_d.data_o   = TX_BEAT.data;
            pins_d.data_oe  = 4'hf;
            pins_d.valid_o  = TX_BEAT.valid;
            pins_d.valid_oe = 1'b1;
         end
         POMX_ROLE_PHY, POMX_ROLE_FAST: begin
            pins_d.data_o   = TX_BEAT.data;
            pins_d.data_oe  = {4{!lk_iso_s2_q}};
            pins_d.valid_o  = TX_BEAT.valid;
            pins_d.valid_oe = !lk_iso_s2_q;
         end
         POMX_ROLE_RED: begin
            // Upper bits driven low but released
            pins_d.data_o   = {2'h0, TX_BEAT.data[1:0]};
            pins_d.data_oe  = {2'h0, {2{!lk_iso_s2_q}}};
            pins_d.valid_o  = TX_BEAT.valid;
            pins_d.valid_oe = !lk_iso_s2_q;
         end
         default: begin
            // Reserved code: nothing driven, strap pins left to their pulls
            pins_d = '0;
         end
      endcase
   end

   // Output flops on the link reference clock
   always_ff @(posedge LINK_CLK or negedge LINK_RST_B) begin
      if (!LINK_RST_B) begin
         pins_q <= '0;
      end else begin
         pins_q <= pins_d;
      end
   end

   assign DATA_O   = pins_q.data_o;
   assign DATA_OE  = pins_q.data_oe;
   assign VALID_O  = pins_q.valid_o;
   assign VALID_OE = pins_q.valid_oe;

   // Isolated PHY roles never drive data or valid
   chk_isolate_off: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      ($past(lk_iso_s2_q) && ($past(lk_role) != POMX_ROLE_MAC))
         |-> (DATA_OE == 4'h0) && !VALID_OE)
      else $error("driver enabled while isolated");

   // MAC role forwards the beat one link clock later
   chk_mac_data: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role == POMX_ROLE_MAC) ##1 (lk_role == POMX_ROLE_MAC)
         |-> (DATA_O == $past(TX_BEAT.data)) && (DATA_OE == 4'hf))
      else $error("mac data mismatch");

   // MAC valid pin follows transmit enable
   chk_mac_valid: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role == POMX_ROLE_MAC) |=> (VALID_O == $past(TX_BEAT.valid)) && VALID_OE)
      else $error("mac valid mismatch");

   // PHY roles carry receive data when not isolated
   chk_phy_data: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      ((lk_role == POMX_ROLE_PHY) || (lk_role == POMX_ROLE_FAST)) && !lk_iso_s2_q
         |=> (DATA_O == $past(TX_BEAT.data)) && (DATA_OE == 4'hf))
      else $error("phy data mismatch");

   // PHY valid pin carries receive data valid
   chk_phy_valid: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      ((lk_role == POMX_ROLE_PHY) || (lk_role == POMX_ROLE_FAST)) && !lk_iso_s2_q
         |=> (VALID_O == $past(TX_BEAT.valid)) && VALID_OE)
      else $error("phy valid mismatch");

   // Reduced role uses only the two low bits
   chk_red_bits: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role == POMX_ROLE_RED) |=> (DATA_OE[3:2] == 2'h0) && (DATA_O[3:2] == 2'h0)
         && (DATA_O[1:0] == $past(TX_BEAT.data[1:0])))
      else $error("reduced role drove upper bits");

   // Reduced valid pin is carrier-and-valid
   chk_red_valid: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role == POMX_ROLE_RED) && !lk_iso_s2_q |=> VALID_O == $past(TX_BEAT.valid))
      else $error("reduced valid mismatch");

   // Double-rate codes pick clock strength from bit 0
   chk_fast_clock: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (role == POMX_ROLE_FAST) |-> DOUBLE_RATE && CLK_IS_OUTPUT && (CLK_STRONG == strap_q[0]))
      else $error("double rate clock setup wrong");

   // Reduced clock direction and strength by code
   chk_red_clock: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (role == POMX_ROLE_RED) |-> (CLK_IS_OUTPUT == (strap_q != CODE_RED_CKIN))
         && (CLK_STRONG == (strap_q == CODE_RED_HI)))
      else $error("reduced clock setup wrong");

   // Once caught, the strap stays frozen until the next reset
   chk_strap_hold: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      strap_done_q |=> $stable(strap_q) && strap_done_q)
      else $error("strap changed after capture");

   // Reserved code flagged and clock driver off
   chk_reserved: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      strap_done_q && (strap_q == CODE_RESERVED) |-> MODE_RESERVED && !CLK_OE)
      else $error("reserved code not flagged");

   // Strap is taken from the second sync stage on the last settle cycle
   chk_capture_pins: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      !strap_done_q && (settle_q == STRAP_SETTLE)
         |=> strap_done_q && (strap_q == $past(strap_s2_q)))
      else $error("strap not taken from the pins");

   // Clock driver is off once isolate has passed the synchroniser
   chk_clock_isolate: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      $past(RST_B, 2) && $past(ISOLATE, 2) |-> !CLK_OE)
      else $error("clock driven while isolated");

   // Pins stay released while the role is unknown or reserved
   chk_unknown_quiet: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role == POMX_ROLE_NONE) |=> (DATA_OE == 4'h0) && !VALID_OE)
      else $error("pins driven without a role");

   // Link copy of the role agrees with the core decode once it has crossed
   chk_role_cross: assert property (
      @(posedge LINK_CLK) disable iff (!LINK_RST_B)
      (lk_role != POMX_ROLE_NONE) |-> strap_done_q && (lk_role == role))
      else $error("link role differs from strap");

   // Double-rate flag only for the two 200 Mbps codes
   chk_fast_only: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      DOUBLE_RATE |-> (role == POMX_ROLE_FAST))
      else $error("double rate outside fast role");

   // MAC role takes the reference clock from the external PHY
   chk_mac_clock_in: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (role == POMX_ROLE_MAC) |-> !CLK_IS_OUTPUT && !CLK_OE)
      else $error("mac role drives the clock");

   // Normal PHY role drives the clock at low strength, single rate
   chk_phy_clock: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (role == POMX_ROLE_PHY) |-> CLK_IS_OUTPUT && !CLK_STRONG && !DOUBLE_RATE)
      else $error("phy clock setup wrong");

endmodule // pomx_port0_out_mux

/* pomx_far_side_model.sv */
// Far-side model: strap resistors, resolved data pins and the free-running reference clock
`timescale 1ns/10ps
module pomx_far_side_model
   import pomx_pkg::*;
(
   input  wire logic [2:0] STRAP_LEVEL,  // Strap resistor levels on pins 2:0
   input  wire logic [3:0] DATA_O,       // Device data pin levels
   input  wire logic [3:0] DATA_OE,      // Device data pin enables
   output logic            LINK_CLK,     // Reference clock made by the far side
   output logic      [3:0] PIN_BUS       // Resolved levels on the data wires
);
   logic last3_q = 1'b0;  // Last level driven on pin 3, which has no resistor

   // 64 ns reference clock with an odd offset, so it has no phase tie to the core clock
   initial begin
      LINK_CLK = 1'b0;
      #7;
      forever #32 LINK_CLK = ~LINK_CLK;
   end

   // Remember pin 3 while driven; released, it shows the inverse so a stale level cannot pass
   always @(DATA_O[3] or DATA_OE[3]) begin
      if (DATA_OE[3]) last3_q = DATA_O[3];
   end

   // Strap resistors hold pins 2:0 whenever the device lets go of them
   always_comb begin
      for (int n = 0; n < 3; n++)
         PIN_BUS[n] = DATA_OE[n] ? DATA_O[n] : STRAP_LEVEL[n];
      PIN_BUS[3] = DATA_OE[3] ? DATA_O[3] : ~last3_q;
   end
endmodule // pomx_far_side_model

/* pomx_port0_out_mux_test.sv */
// Self-checking bench for the port 0 output pin multiplexer
`timescale 1ns/10ps
module pomx_port0_out_mux_test;
   import pomx_pkg::*;
   logic       core_clk;     // Core clock, 40 ns
   logic       rst_b;        // Core reset, active low
   logic       link_rst_b;   // Link reset, active low
   logic [2:0] strap_level;  // Strap resistor levels
   logic       isolate;      // Isolate control
   pomx_beat_t tx_beat;      // Beat toward the pins
   logic       link_clk;     // Reference clock from the model
   logic [3:0] data_o;       // Data pin levels
   logic [3:0] data_oe;      // Data pin enables
   logic [3:0] pin_bus;      // Resolved wires
   logic       valid_o;      // Valid pin level
   logic       valid_oe;     // Valid pin enable
   logic [2:0] role_code;    // Captured strap
   logic       strap_done;   // Capture done
   logic       clk_is_out;   // Device drives ref clock
   logic       clk_strong;   // Strong clock drive
   logic       clk_oe;       // Clock driver enable
   logic       double_rate;  // 200 Mbps role
   logic       mode_rsv;     // Reserved code flag
   int         mismatches;   // Failed comparisons
   int         tests_run;    // All comparisons

   pomx_port0_out_mux pomx_port0_out_mux_i (.CORE_CLK(core_clk), .RST_B(rst_b),
      .LINK_CLK(link_clk), .LINK_RST_B(link_rst_b), .STRAP_PIN_I(pin_bus[2:0]),
      .ISOLATE(isolate), .TX_BEAT(tx_beat), .DATA_O(data_o), .DATA_OE(data_oe),
      .VALID_O(valid_o), .VALID_OE(valid_oe), .ROLE_CODE(role_code),
      .STRAP_DONE(strap_done), .CLK_IS_OUTPUT(clk_is_out), .CLK_STRONG(clk_strong),
      .CLK_OE(clk_oe), .DOUBLE_RATE(double_rate), .MODE_RESERVED(mode_rsv));
   pomx_far_side_model pomx_far_side_model_i (.STRAP_LEVEL(strap_level), .DATA_O(data_o),
      .DATA_OE(data_oe), .LINK_CLK(link_clk), .PIN_BUS(pin_bus));

   // Core clock: 25 MHz
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Compare one value and count it
   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Print the counts and the verdict, then stop
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Reset with a strap code, then check decode, capture timing and the stream on the pins
   task automatic test_code(input logic [2:0] code);
      logic [3:0] d;
      logic       red;
      logic       res;
      logic [2:0] pins_exp;
      d = 4'(code) ^ 4'ha;
      red = code inside {CODE_RED_LO, CODE_RED_HI, CODE_RED_CKIN};
      res = (code == CODE_RESERVED);
      // Released pins show the strap resistors; pin 2 is released in the reduced role
      pins_exp = res ? code : red ? {code[2], d[1:0]} : d[2:0];
      @(posedge core_clk);
      strap_level <= code;
      rst_b <= 1'b0;
      link_rst_b <= 1'b0;
      isolate <= 1'b0;
      tx_beat <= '{4'h0, 1'b0};
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      link_rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check(4'(strap_done), 4'h0, "done early");
      @(posedge core_clk);
      #1 check(4'(strap_done), 4'h1, "done late");
      check(4'(role_code), 4'(code), "role code");
      check(4'(clk_is_out), 4'(code inside {[3'h1:3'h5]}), "clock dir");
      check(4'(clk_oe), 4'(code inside {[3'h1:3'h5]}), "clock enable");
      check(4'(clk_strong), 4'(code inside {3'h3, 3'h5}), "clock strength");
      check(4'(double_rate), 4'(code inside {3'h2, 3'h3}), "double rate");
      check(4'(mode_rsv), 4'(res), "reserved flag");
      repeat (8) @(posedge link_clk);
      tx_beat <= '{d, 1'b1};
      @(posedge link_clk);
      @(negedge link_clk);
      check(data_oe, res ? 4'h0 : red ? 4'h3 : 4'hf, "data enables");
      check(4'(pin_bus[2:0]), 4'(pins_exp), "pins");
      if (!res && !red) check(4'(pin_bus[3]), 4'(d[3]), "pin 3");
      if (red) check(4'(data_o[3:2]), 4'h0, "unused bits");
      check(4'(valid_oe), 4'(!res), "valid enable");
      if (!res) check(4'(valid_o), 4'h1, "valid high");
      // Next beat launched on a rising link clock edge, like the beat before it
      @(posedge link_clk);
      tx_beat <= '{d, 1'b0};
      @(posedge link_clk);
      @(negedge link_clk);
      if (!res) check(4'(valid_o), 4'h0, "valid low");
      check(4'(role_code), 4'(code), "strap held");
      $display("Strap code %0d done", code);
   endtask

   // Isolate turns off PHY-role pin drivers and the clock driver, but not in MAC role
   task automatic isolate_test(input logic [2:0] code);
      logic phy;
      phy = (code != CODE_MAC);
      test_code(code);
      @(posedge core_clk);
      isolate <= 1'b1;
      repeat (8) @(posedge link_clk);
      @(negedge link_clk);
      check(data_oe, phy ? 4'h0 : 4'hf, "isolated data");
      check(4'(valid_oe), 4'(!phy), "isolated valid");
      check(4'(clk_oe), 4'h0, "isolated clock");
      if (phy) check(4'(pin_bus[2:0]), 4'(code), "isolated pins");
      @(posedge core_clk);
      isolate <= 1'b0;
      repeat (8) @(posedge link_clk);
      @(negedge link_clk);
      check(4'(valid_oe), 4'h1, "released valid");
      check(data_oe, (code == CODE_RED_LO) ? 4'h3 : 4'hf, "released data");
      $display("Isolate with code %0d done", code);
   endtask

   // Main sequence: every strap code, then isolate in three roles
   initial begin
      rst_b = 1'b0;
      link_rst_b = 1'b0;
      strap_level = CODE_RESERVED;
      isolate = 1'b0;
      tx_beat = '0;
      mismatches = 0;
      tests_run = 0;
      for (int c = 0; c < 8; c++) test_code(3'(c));
      isolate_test(CODE_MAC);
      isolate_test(CODE_PHY);
      isolate_test(CODE_RED_LO);
      conclude();
   end
endmodule // pomx_port0_out_mux_test
